/* File: logic/vcr_pkg.sv */
// Contract
// - format byte reports vid mode, table parameter
// - format byte writes refused, fault flagged
// - command carries right-justified vid, lsb bit 0
// - every vid translated through selected table
// - upper byte reads zero, low byte writable
// - commanded output never exceeds upper limit
// - over-limit attempt is a warning only
// - over-limit write clamps to limit value
// - over-limit sets other and limit-warning bits
// - over-limit attempt raises host alert
// - limit writable, resets to 00ff
// - margin-high holds target, resets to 0000
package vcr_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0]  CMD_FORMAT       = 8'h20; // output_format_descriptor
    localparam logic [7:0]  CMD_VOLTAGE      = 8'h21; // output_voltage_command
    localparam logic [7:0]  CMD_LIMIT        = 8'h24; // output_voltage_limit
    localparam logic [7:0]  CMD_MARGIN_HIGH  = 8'h25; // margin_high_target
    localparam logic [7:0]  CMD_VENDOR_CFG   = 8'hdd; // vendor_config_cmd
    ////////////////////////////////////////////////////////////////////////////////
    // format byte fields
    localparam logic [2:0]  FMT_MODE_VID     = 3'h1;  // vid mode
    localparam logic [4:0]  FMT_PARAM_FINE   = 5'h02; // vid_table_fine
    localparam logic [4:0]  FMT_PARAM_LEGACY = 5'h01; // vid_table_legacy
    // vendor config fields
    localparam int          VCFG_FINE_BIT    = 0;     // table choice when overriding
    localparam int          VCFG_OVR_BIT     = 7;     // 1: use register, not pin
    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  LIMIT_RESET      = 8'hff;
    localparam logic [7:0]  MARGIN_RESET     = 8'h00;
    localparam logic [7:0]  VCFG_RESET       = 8'h00;
    localparam logic [7:0]  UPPER_BYTE       = 8'h00; // reserved upper byte value
endpackage : vcr_pkg

/* File: logic/vcr_top.sv */
`timescale 1ns/10ps
// output voltage command register set with limit clamp
module vcr_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_slew_select_pin,  // strap: 1 fine table, 0 legacy
    input  wire logic [7:0]  i_boot_voltage,     // boot vid code, sampled after reset
    input  wire logic        i_wr_valid,         // one-cycle write request
    input  wire logic        i_rd_valid,         // one-cycle read request
    input  wire logic [7:0]  i_cmd_code,         // command code of the request
    input  wire logic [15:0] i_wr_data,          // write data word, low byte first
    input  wire logic        i_margin_high_sel,  // operation selects margin high
    input  wire logic        i_status_clear,     // clears warn, other and alert
    input  wire logic        i_cml_clear,        // clears communication fault
    output logic      [15:0] o_rd_data,          // read answer
    output logic             o_rd_ack,           // read answer strobe
    output logic             o_cmd_refused,      // write refused pulse
    output logic             o_cml_fault,        // invalid data fault, sticky
    output logic             o_status_other,     // other bit, sticky
    output logic             o_limit_warn,       // upper-limit warning, sticky
    output logic             o_alert_b,          // host alert, active low
    output logic             o_table_fine,       // selected table
    output logic      [7:0]  o_commanded_level_field, // effective vid target
    output logic      [15:0] o_target_level,     // translated target
    output logic      [15:0] o_limit_level       // translated limit
);
    import vcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_meta_r;  // first stage
    logic rst_b;       // released reset

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_b      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_b      <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] cmd_r;      // output_voltage_command low byte
    logic [7:0] limit_r;    // output_voltage_limit low byte
    logic [7:0] margin_r;   // margin_high_target low byte
    logic [7:0] vcfg_r;     // vendor config byte
    logic       strap_r;    // captured strap
    logic       booted_r;   // boot load done
    logic       fine;       // table in use
    logic       wr_cmd;     // write to command register
    logic       over_limit; // over-limit attempt
    logic [7:0] tgt_nxt;    // effective target

    assign wr_cmd     = i_wr_valid && (i_cmd_code == CMD_VOLTAGE);
    assign over_limit = wr_cmd && (i_wr_data[7:0] > limit_r);
    assign fine       = vcfg_r[VCFG_OVR_BIT] ? vcfg_r[VCFG_FINE_BIT] : strap_r;

    // strap and boot code are caught after reset release
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            booted_r <= 1'b0;
            strap_r  <= 1'b0;
        end else if (!booted_r) begin
            booted_r <= 1'b1;
            strap_r  <= i_slew_select_pin;
        end
    end

    // command register: boot load, then host writes clamped to limit
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r <= 8'h00;
        end else if (!booted_r) begin
            cmd_r <= i_boot_voltage;
        end else if (over_limit) begin
            cmd_r <= limit_r;
        end else if (wr_cmd) begin
            cmd_r <= i_wr_data[7:0];
        end
    end

    // limit, margin and vendor config writes; upper byte discarded
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_r  <= LIMIT_RESET;
            margin_r <= MARGIN_RESET;
            vcfg_r   <= VCFG_RESET;
        end else if (i_wr_valid) begin
            case (i_cmd_code)
                CMD_LIMIT:       limit_r  <= i_wr_data[7:0];
                CMD_MARGIN_HIGH: margin_r <= i_wr_data[7:0];
                CMD_VENDOR_CFG:  vcfg_r   <= i_wr_data[7:0];
                default: begin
                    vcfg_r <= vcfg_r; // other codes leave these alone
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // refusal of format byte writes; set wins over clear
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_cmd_refused <= 1'b0;
            o_cml_fault   <= 1'b0;
        end else begin
            o_cmd_refused <= i_wr_valid && (i_cmd_code == CMD_FORMAT);
            if (i_wr_valid && (i_cmd_code == CMD_FORMAT)) begin
                o_cml_fault <= 1'b1;
            end else if (i_cml_clear) begin
                o_cml_fault <= 1'b0;
            end
        end
    end

    // over-limit warning status and alert; set wins over clear
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_status_other <= 1'b0;
            o_limit_warn   <= 1'b0;
            o_alert_b      <= 1'b1;
        end else if (over_limit) begin
            o_status_other <= 1'b1;
            o_limit_warn   <= 1'b1;
            o_alert_b      <= 1'b0;
        end else if (i_status_clear) begin
            o_status_other <= 1'b0;
            o_limit_warn   <= 1'b0;
            o_alert_b      <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // effective target, never above the limit whatever the mix
    always_comb begin
        tgt_nxt = i_margin_high_sel ? margin_r : cmd_r;
        if (tgt_nxt > limit_r) begin
            tgt_nxt = limit_r;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_commanded_level_field <= 8'h00;
            o_table_fine            <= 1'b0;
        end else begin
            o_commanded_level_field <= tgt_nxt;
            o_table_fine            <= fine;
        end
    end

    // translation of target and limit through the chosen table
    vcr_vid_xlate u_xlate_target (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .i_fine  (fine),
        .i_code  (tgt_nxt),
        .o_level (o_target_level)
    );

    vcr_vid_xlate u_xlate_limit (
        .i_clk   (i_clk),
        .i_rst_b (rst_b),
        .i_fine  (fine),
        .i_code  (limit_r),
        .o_level (o_limit_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read answer one cycle after the request; unknown codes read zero
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rd_data <= 16'h0000;
            o_rd_ack  <= 1'b0;
        end else begin
            o_rd_ack <= i_rd_valid;
            if (i_rd_valid) begin
                case (i_cmd_code)
                    CMD_FORMAT:      o_rd_data <= {UPPER_BYTE, FMT_MODE_VID,
                                                   fine ? FMT_PARAM_FINE : FMT_PARAM_LEGACY};
                    CMD_VOLTAGE:     o_rd_data <= {UPPER_BYTE, cmd_r};
                    CMD_LIMIT:       o_rd_data <= {UPPER_BYTE, limit_r};
                    CMD_MARGIN_HIGH: o_rd_data <= {UPPER_BYTE, margin_r};
                    CMD_VENDOR_CFG:  o_rd_data <= {UPPER_BYTE, vcfg_r};
                    default:         o_rd_data <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    clamp_write_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        booted_r && over_limit |=> cmd_r == $past(limit_r))
        else $error("over-limit write not clamped");
    never_above_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        o_commanded_level_field <= $past(limit_r))
        else $error("target above limit");
    warn_bits_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        over_limit |=> o_status_other && o_limit_warn)
        else $error("warn bits not set");
    alert_raise_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        over_limit |=> !o_alert_b)
        else $error("alert not raised");
    warn_not_fault_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        over_limit && !(i_wr_valid && i_cmd_code == CMD_FORMAT) && !o_cml_fault |=> !o_cml_fault)
        else $error("over-limit flagged as fault");
    format_refuse_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_wr_valid && i_cmd_code == CMD_FORMAT |=> o_cml_fault && o_cmd_refused)
        else $error("format write not refused");
    format_read_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_rd_valid && i_cmd_code == CMD_FORMAT |=> o_rd_ack &&
        o_rd_data == {8'h00, 3'b001, $past(fine) ? 5'b00010 : 5'b00001})
        else $error("format byte wrong");
    upper_zero_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        o_rd_ack |-> o_rd_data[15:8] == 8'h00)
        else $error("upper byte not zero");
    boot_load_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        !booted_r |=> cmd_r == $past(i_boot_voltage))
        else $error("boot code not loaded");
    limit_write_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_wr_valid && i_cmd_code == CMD_LIMIT |=> limit_r == $past(i_wr_data[7:0]))
        else $error("limit write lost");
    margin_use_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_margin_high_sel && margin_r <= limit_r |=> o_commanded_level_field == $past(margin_r))
        else $error("margin target not used");
    write_lsb_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        booted_r && wr_cmd && !over_limit |=> cmd_r == $past(i_wr_data[7:0]))
        else $error("command write lost");
    table_pick_a: assert property (@(posedge i_clk) disable iff (!rst_b)
        vcfg_r[7] |=> o_table_fine == $past(vcfg_r[0]))
        else $error("vendor table choice ignored");
endmodule : vcr_top

/* File: logic/vcr_vid_xlate.sv */
`timescale 1ns/10ps
// registered vid code to level translation, two tables
module vcr_vid_xlate #(
    parameter logic [15:0] LEGACY_BASE = 16'h00fa, // level of code 1, legacy table
    parameter logic [15:0] LEGACY_STEP = 16'h0005, // level step, legacy table
    parameter logic [15:0] FINE_BASE   = 16'h01f4, // level of code 1, fine table
    parameter logic [15:0] FINE_STEP   = 16'h000a  // level step, fine table
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_fine,   // table select
    input  wire logic [7:0]  i_code,   // vid code
    output logic      [15:0] o_level   // translated level, 0 for code 0
);
    logic [15:0] base; // selected table base
    logic [15:0] step; // selected table step
    logic [31:0] prod; // full width product

    ////////////////////////////////////////////////////////////////////////////////
    // table pick and linear map
    always_comb begin
        base = i_fine ? FINE_BASE : LEGACY_BASE;
        step = i_fine ? FINE_STEP : LEGACY_STEP;
        prod = {24'h000000, i_code - 8'h01} * {16'h0000, step};
    end

    // code 0 means output off
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_level <= 16'h0000;
        end else if (i_code == 8'h00) begin
            o_level <= 16'h0000;
        end else begin
            o_level <= base + prod[15:0];
        end
    end
endmodule : vcr_vid_xlate

/* File: test/output_voltage_command_registers_test.sv */
`timescale 1ns/10ps
module output_voltage_command_registers_test;
    import vcr_pkg::*;
    // one table row: write flag, command, write word, expected read
    typedef struct packed {logic wr; logic [7:0] code; logic [15:0] data; logic [15:0] exp;} vcr_row_t;
    logic        clk = 1'b0, rst_b = 1'b0, slew = 1'b0, msel = 1'b0, sclr = 1'b0, cclr = 1'b0;
    logic [7:0]  boot = 8'h30;
    logic        wr_valid, rd_valid, rd_ack, refused, cml, other, warn, alert_b, fine;
    logic [7:0]  code, field;
    logic [15:0] wr_data, rd_data, tgt, lim, rd;
    int          n_errors = 0, samples_checked = 0, cycles = 0;
    // level of code 0x80 under the translator's default table parameters: base + (code - 1) * step
    localparam logic [15:0] LVL_LEGACY_80 = 16'h0375; // legacy table
    localparam logic [15:0] LVL_FINE_80   = 16'h06ea; // fine table
    vcr_row_t    rows [8] = '{
        '{1'b0, 8'h20, 16'h0000, 16'h0021},
        '{1'b0, 8'h24, 16'h0000, 16'h00ff},
        '{1'b0, 8'h25, 16'h0000, 16'h0000},
        '{1'b0, 8'h21, 16'h0000, 16'h0030},
        '{1'b1, 8'h21, 16'h5a5a, 16'h005a},
        '{1'b1, 8'h25, 16'hff77, 16'h0077},
        '{1'b1, 8'h24, 16'h1280, 16'h0080},
        '{1'b0, 8'h33, 16'h0000, 16'h0000}};
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 20 ns period
    always #10 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    vcr_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_slew_select_pin(slew), .i_boot_voltage(boot),
        .i_wr_valid(wr_valid), .i_rd_valid(rd_valid), .i_cmd_code(code), .i_wr_data(wr_data),
        .i_margin_high_sel(msel), .i_status_clear(sclr), .i_cml_clear(cclr), .o_rd_data(rd_data),
        .o_rd_ack(rd_ack), .o_cmd_refused(refused), .o_cml_fault(cml), .o_status_other(other),
        .o_limit_warn(warn), .o_alert_b(alert_b), .o_table_fine(fine), .o_commanded_level_field(field),
        .o_target_level(tgt), .o_limit_level(lim));
    vcr_host_model host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_ack(rd_ack), .o_wr_valid(wr_valid),
        .o_rd_valid(rd_valid), .o_cmd_code(code), .o_wr_data(wr_data));
    ////////////////////////////////////////////////////////////////////////////////
    // compare seen against expected
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // print counts and verdict, then stop
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 check({15'h0, alert_b}, 16'h0001); // alert idles high in reset
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        // table rows: optional write, then read back
        foreach (rows[i]) begin
            if (rows[i].wr) host.write(rows[i].code, rows[i].data);
            host.read(rows[i].code, rd);
            check(rd, rows[i].exp);
        end
        // command above the 0x80 limit: clamp and warn
        host.write(CMD_VOLTAGE, 16'h0090);
        #1 check({15'h0, other}, 16'h0001);
        check({15'h0, warn}, 16'h0001);
        check({15'h0, alert_b}, 16'h0000);
        check({15'h0, cml}, 16'h0000);
        @(posedge clk);
        #1 check({8'h0, field}, 16'h0080);
        check(tgt, lim);
        check(lim, LVL_LEGACY_80);
        host.read(CMD_VOLTAGE, rd);
        check(rd, 16'h0080);
        // margin high selected, below then above the limit
        @(posedge clk) msel <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({8'h0, field}, 16'h0077);
        host.write(CMD_MARGIN_HIGH, 16'h00ff);
        repeat (2) @(posedge clk);
        #1 check({8'h0, field}, 16'h0080);
        // status clear releases the alert
        @(posedge clk) sclr <= 1'b1;
        @(posedge clk) sclr <= 1'b0;
        #1 check({13'h0, other, warn, alert_b}, 16'h0001);
        // format byte write refused, one pulse, fault raised
        host.write(CMD_FORMAT, 16'h00e3);
        #1 check({14'h0, refused, cml}, 16'h0003);
        @(posedge clk);
        #1 check({15'h0, refused}, 16'h0000);
        host.read(CMD_FORMAT, rd);
        check(rd, 16'h0021);
        // vendor config overrides the strap to the fine table
        host.write(CMD_VENDOR_CFG, 16'h0081);
        @(posedge clk);
        #1 check({15'h0, fine}, 16'h0001);
        check(lim, LVL_FINE_80);
        host.read(CMD_FORMAT, rd);
        check(rd, 16'h0022);
        @(posedge clk) cclr <= 1'b1;
        @(posedge clk) cclr <= 1'b0;
        #1 check({15'h0, cml}, 16'h0000);
        // mid-run reset: fine strap, new boot code, defaults come back
        @(posedge clk) rst_b <= 1'b0;
        msel <= 1'b0;
        slew <= 1'b1;
        boot <= 8'h45;
        repeat (3) @(posedge clk);
        #1 check({13'h0, other, cml, alert_b}, 16'h0001);
        @(posedge clk) rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        host.read(CMD_FORMAT, rd);
        check(rd, 16'h0022);
        host.read(CMD_VOLTAGE, rd);
        check(rd, 16'h0045);
        check({8'h0, field}, 16'h0045);
        host.read(CMD_LIMIT, rd);
        check(rd, 16'h00ff);
        host.read(CMD_MARGIN_HIGH, rd);
        check(rd, 16'h0000);
        // vendor config overrides the fine strap back to legacy
        host.write(CMD_VENDOR_CFG, 16'h0080);
        host.read(CMD_FORMAT, rd);
        check(rd, 16'h0021);
        complete_run();
    end
endmodule : output_voltage_command_registers_test

/* File: test/vcr_host_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host side of the register port: one request per call, driven after the edge
module vcr_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_ack,
    output logic             o_wr_valid,
    output logic             o_rd_valid,
    output logic      [7:0]  o_cmd_code,
    output logic      [15:0] o_wr_data
);
    // idle bus at time zero
    initial begin
        o_wr_valid = 1'b0;
        o_rd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_wr_data  = 16'h0000;
    end
    // one write word, vid code right-justified with its lsb in bit 0
    task automatic write(input logic [7:0] code, input logic [15:0] data);
        @(posedge i_clk);
        o_wr_valid <= 1'b1;
        o_cmd_code <= code;
        o_wr_data  <= data;
        @(posedge i_clk);
        o_wr_valid <= 1'b0;
        o_wr_data  <= ~data; // released data must not look held
    endtask : write
    // one read, answer taken at the edge where the ack is high
    task automatic read(input logic [7:0] code, output logic [15:0] data);
        @(posedge i_clk);
        o_rd_valid <= 1'b1;
        o_cmd_code <= code;
        @(posedge i_clk);
        o_rd_valid <= 1'b0;
        @(posedge i_clk);
        data = (i_rd_ack === 1'b1) ? i_rd_data : 16'hxxxx;
    endtask : read
endmodule : vcr_host_model
